// *** src/bmf_pkg.sv ***
// constants, types and piece functions shared by the bus-matching buffer
package bmf_pkg;

  // ==========================================================================
  // geometry
  // ==========================================================================
  localparam int unsigned DEPTH = 1024;
  localparam int unsigned AW = 10;
  localparam int unsigned DW = 36;
  localparam int unsigned CW = 11;
  localparam int unsigned HALF_W = 18;
  localparam int unsigned BYTE_W = 9;
  localparam logic [CW-1:0] DEPTH_CNT = 11'h400;
  localparam logic [CW-1:0] HALF_CNT = 11'h201;
  localparam logic [1:0] BUF_ENTRIES = 2'h2;
  // rising read clock edges before the first word falls through
  localparam logic [1:0] FALL_EDGES = 2'h3;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [2:0] {
    W36 = 3'b001,
    W18 = 3'b010,
    W9 = 3'b100
  } bmf_width_t;

  typedef struct packed {
    logic fall_through;
    logic big_endian;
    logic wr_strobe;
    logic rd_strobe;
    bmf_width_t in_width;
    bmf_width_t out_width;
  } bmf_cfg_t;

  typedef struct packed {
    logic wclk;
    logic wstb;
    logic wen_n;
    logic rclk;
    logic rstb;
    logic ren_n;
    logic rcs_n;
    logic oe_n;
    logic mrs_n;
    logic prs_n;
    logic iw;
    logic ow;
    logic bm;
    logic fall_through_mode;
    logic be_n;
    logic wsel;
    logic rsel;
    logic [DW-1:0] data;
  } bmf_pins_t;

  typedef struct packed {
    logic en;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } bmf_mem_wr_t;

  typedef struct packed {
    bmf_pins_t meta;
    bmf_pins_t sync;
    logic wclk_prev;
    logic wstb_prev;
    logic rclk_prev;
    logic rstb_prev;
    bmf_cfg_t cfg;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] mem_cnt;
    logic inflight;
    logic [1:0][DW-1:0] buf_data;
    logic [1:0] buf_cnt;
    logic buf_head;
    logic [DW-1:0] asm_word;
    logic [1:0] asm_idx;
    logic [DW-1:0] cur_word;
    logic [1:0] cur_rem;
    logic out_valid;
    logic [1:0] fall_cnt;
    logic [DW-1:0] q;
    logic q_oe;
    logic ef_n;
    logic ff_n;
    logic hf_n;
  } bmf_state_t;

  localparam bmf_cfg_t CFG_RESET = '{fall_through: 1'b0, big_endian: 1'b0, wr_strobe: 1'b0,
                                     rd_strobe: 1'b0, in_width: W36, out_width: W36};
  // synchronisers wake at the pins' idle levels, so no false pin reset or drive follows reset
  localparam bmf_pins_t PINS_IDLE = '{wen_n: 1'b1, ren_n: 1'b1, rcs_n: 1'b1, oe_n: 1'b1, mrs_n: 1'b1, prs_n: 1'b1,
                                      be_n: 1'b1, default: '0};
  localparam bmf_state_t ST_RESET = '{meta: PINS_IDLE, sync: PINS_IDLE, cfg: CFG_RESET, ef_n: 1'b0, ff_n: 1'b1,
                                      hf_n: 1'b1, default: '0};

  // ==========================================================================
  // functions
  // ==========================================================================
  function automatic logic [1:0] last_index(input bmf_width_t wd);
    unique case (wd)
      W18: return 2'h1;
      W9: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  // big-endian hands out the most significant piece first
  function automatic logic [1:0] piece_pos(input bmf_width_t wd, input logic [1:0] idx, input logic be);
    return be ? 2'(last_index(wd) - idx) : idx;
  endfunction

  function automatic logic [DW-1:0] get_piece(input logic [DW-1:0] w, input bmf_width_t wd, input logic [1:0] pos);
    logic [DW-1:0] r;
    r = '0;
    unique case (wd)
      W18: r[HALF_W-1:0] = w[pos[0]*HALF_W +: HALF_W];
      W9: r[BYTE_W-1:0] = w[pos*BYTE_W +: BYTE_W];
      default: r = w;
    endcase
    return r;
  endfunction

  function automatic logic [DW-1:0] place_piece(input logic [DW-1:0] w, input logic [DW-1:0] d,
                                                input bmf_width_t wd, input logic [1:0] pos);
    logic [DW-1:0] r;
    r = w;
    unique case (wd)
      W18: r[pos[0]*HALF_W +: HALF_W] = d[HALF_W-1:0];
      W9: r[pos*BYTE_W +: BYTE_W] = d[BYTE_W-1:0];
      default: r = d;
    endcase
    return r;
  endfunction

  // unlisted pin combinations with matching off fall back to 36/36
  function automatic bmf_cfg_t decode_cfg(input bmf_pins_t p);
    bmf_cfg_t c;
    c = CFG_RESET;
    c.fall_through = p.fall_through_mode;
    c.big_endian = !p.be_n;
    c.wr_strobe = p.wsel;
    c.rd_strobe = p.rsel;
    if (p.bm) begin
      unique case ({p.iw, p.ow})
        2'b00: c.out_width = W18;
        2'b01: c.out_width = W9;
        2'b10: c.in_width = W18;
        2'b11: c.in_width = W9;
      endcase
    end
    return c;
  endfunction

endpackage

// *** src/bmf_mem.sv ***
// storage array of the bus-matching buffer, one write and one registered read port
`timescale 1ns/1ps
`default_nettype none
module bmf_mem (
  input wire logic clock,
  input wire logic rstn,
  input wire bmf_pkg::bmf_mem_wr_t wr_port,
  input wire logic rd_en,
  input wire logic [bmf_pkg::AW-1:0] rd_addr,
  output logic [bmf_pkg::DW-1:0] rd_data
);
  import bmf_pkg::*;

  logic [DW-1:0] mem_array [DEPTH];
  logic [DW-1:0] rd_data_reg;

  // the array carries no reset so that it maps onto block memory
  always_ff @(posedge clock) begin
    if (wr_port.en) begin
      mem_array[wr_port.addr] <= wr_port.data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data_reg <= '0;
    end else if (rd_en) begin
      rd_data_reg <= mem_array[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;

endmodule
`default_nettype wire

// *** src/bmf_top.sv ***
// bus-matching first-in-first-out buffer with clocked or strobe ports
// ============================================================================
// Function
// - depth fixed per build, 36-bit entries
// - port widths taken from pins at master reset
// - only 36/36, 36/18, 36/9, 18/36, 9/36
// - clocked write on write clock with enable
// - strobe write on strobe edge alone
// - clocked read on read clock with enable
// - strobe read on strobe edge alone
// - port clocks independent, down to zero
// - standard mode: word shown only after read
// - fall-through: first word after three clock edges
// - timing mode sampled at master reset
// - fall-through outputs chain into next buffer
// - outputs released when output enable deasserted
// - master reset clears all, partial keeps settings
// - empty/full or ready flags, half flag always
// - narrow pieces follow selected byte order
`timescale 1ns/1ps
`default_nettype none
module bmf_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic write_clock_pin,
  input wire logic write_strobe_pin,
  input wire logic write_enable_n,
  input wire logic [bmf_pkg::DW-1:0] input_data_bus,
  input wire logic read_clock_pin,
  input wire logic read_strobe_pin,
  input wire logic read_enable_n,
  input wire logic output_chip_select_n,
  input wire logic output_enable_n,
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic input_width_pin,
  input wire logic output_width_pin,
  input wire logic width_matching_select,
  input wire logic fall_through_select_serial_in,
  input wire logic byte_order_select_n,
  input wire logic write_strobe_select,
  input wire logic read_strobe_select,
  output logic [bmf_pkg::DW-1:0] output_data_bus,
  output logic output_data_oe,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic half_level_flag_n
);
  import bmf_pkg::*;

  bmf_state_t st_reg;
  bmf_state_t st_next;
  bmf_pins_t pin_raw;
  bmf_mem_wr_t mem_wr;
  logic [DW-1:0] mem_rd_data;
  logic [DW-1:0] asm_full;
  logic [CW-1:0] stored;
  logic [CW-1:0] stored_next;
  logic [1:0] in_last;
  logic [1:0] out_last;
  logic wr_evt;
  logic rd_evt;
  logic rclk_edge;
  logic full;
  logic issue;
  logic push;
  logic pop;
  logic load;
  logic avail;
  logic avail_piece;
  logic wr_slot;

  assign pin_raw = '{wclk: write_clock_pin, wstb: write_strobe_pin, wen_n: write_enable_n,
                     rclk: read_clock_pin, rstb: read_strobe_pin, ren_n: read_enable_n,
                     rcs_n: output_chip_select_n, oe_n: output_enable_n, mrs_n: master_reset_n,
                     prs_n: partial_reset_n, iw: input_width_pin, ow: output_width_pin,
                     bm: width_matching_select, fall_through_mode: fall_through_select_serial_in,
                     be_n: byte_order_select_n, wsel: write_strobe_select, rsel: read_strobe_select,
                     data: input_data_bus};

  // ==========================================================================
  // storage
  // ==========================================================================
  bmf_mem u_mem (
    .clock(clock),
    .rstn(rstn),
    .wr_port(mem_wr),
    .rd_en(issue),
    .rd_addr(st_reg.rd_ptr),
    .rd_data(mem_rd_data)
  );

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    st_next = st_reg;
    // every pin, port clocks included, is sampled through two flops first
    st_next.meta = pin_raw;
    st_next.sync = st_reg.meta;
    st_next.wclk_prev = st_reg.sync.wclk;
    st_next.wstb_prev = st_reg.sync.wstb;
    st_next.rclk_prev = st_reg.sync.rclk;
    st_next.rstb_prev = st_reg.sync.rstb;
    in_last = last_index(st_reg.cfg.in_width);
    out_last = last_index(st_reg.cfg.out_width);

    // port clocks are seen only as sampled edges, so any rate from zero up to below half the clock works
    rclk_edge = st_reg.sync.rclk && !st_reg.rclk_prev;
    wr_evt = st_reg.cfg.wr_strobe ? (st_reg.sync.wstb && !st_reg.wstb_prev) :
             (st_reg.sync.wclk && !st_reg.wclk_prev && !st_reg.sync.wen_n);
    rd_evt = st_reg.cfg.rd_strobe ? (st_reg.sync.rstb && !st_reg.rstb_prev) :
             (rclk_edge && !st_reg.sync.ren_n);

    stored = st_reg.mem_cnt + CW'(st_reg.inflight) + CW'(st_reg.buf_cnt);
    full = (stored == DEPTH_CNT);

    // ------------------------------------------------------------------------
    // write side: narrow pieces gather into one stored word
    // ------------------------------------------------------------------------
    asm_full = place_piece(st_reg.asm_word, st_reg.sync.data, st_reg.cfg.in_width,
                           piece_pos(st_reg.cfg.in_width, st_reg.asm_idx, st_reg.cfg.big_endian));
    mem_wr = '{en: 1'b0, addr: st_reg.wr_ptr, data: asm_full};
    if (wr_evt && !full) begin
      st_next.asm_word = asm_full;
      if (st_reg.asm_idx == in_last) begin
        mem_wr.en = 1'b1;
        st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        st_next.asm_idx = 2'h0;
      end else begin
        st_next.asm_idx = st_reg.asm_idx + 2'h1;
      end
    end

    // ------------------------------------------------------------------------
    // prefetch into the two-entry buffer; only issue what it can take
    // ------------------------------------------------------------------------
    issue = (st_reg.mem_cnt != '0) && ((st_reg.buf_cnt + 2'(st_reg.inflight)) < BUF_ENTRIES);
    push = st_reg.inflight;
    wr_slot = (st_reg.buf_cnt == 2'h1) ? !st_reg.buf_head : st_reg.buf_head;
    st_next.inflight = issue;
    if (issue) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    st_next.mem_cnt = st_reg.mem_cnt + CW'(mem_wr.en) - CW'(issue);
    if (push) begin
      st_next.buf_data[wr_slot] = mem_rd_data;
    end

    // ------------------------------------------------------------------------
    // read side: pieces of the current word, then the buffer head
    // ------------------------------------------------------------------------
    avail_piece = (st_reg.cur_rem != 2'h0);
    avail = avail_piece || (st_reg.buf_cnt != 2'h0);
    if (st_reg.cfg.fall_through) begin
      load = avail && ((st_reg.out_valid && rd_evt) ||
             (!st_reg.out_valid && rclk_edge && st_reg.fall_cnt == 2'(FALL_EDGES - 2'h1)));
    end else begin
      load = avail && rd_evt;
    end
    pop = load && !avail_piece;
    if (load) begin
      if (avail_piece) begin
        st_next.q = get_piece(st_reg.cur_word, st_reg.cfg.out_width,
                              piece_pos(st_reg.cfg.out_width, 2'(out_last - st_reg.cur_rem + 2'h1),
                                        st_reg.cfg.big_endian));
        st_next.cur_rem = st_reg.cur_rem - 2'h1;
      end else begin
        st_next.cur_word = st_reg.buf_data[st_reg.buf_head];
        st_next.q = get_piece(st_reg.buf_data[st_reg.buf_head], st_reg.cfg.out_width,
                              piece_pos(st_reg.cfg.out_width, 2'h0, st_reg.cfg.big_endian));
        st_next.cur_rem = out_last;
      end
    end
    st_next.buf_cnt = st_reg.buf_cnt + 2'(push) - 2'(pop);
    st_next.buf_head = st_reg.buf_head ^ pop;
    // in fall-through the held word feeds a chained buffer's input directly
    st_next.out_valid = load || (st_reg.out_valid && !rd_evt);
    if (st_next.out_valid || !avail || !st_reg.cfg.fall_through) begin
      st_next.fall_cnt = 2'h0;
    end else if (rclk_edge) begin
      st_next.fall_cnt = st_reg.fall_cnt + 2'h1;
    end
    // strobe reads leave the drive to output enable alone
    st_next.q_oe = !st_reg.sync.oe_n && (st_reg.cfg.rd_strobe || !st_reg.sync.rcs_n);

    // ------------------------------------------------------------------------
    // resets from pins: partial keeps the configuration
    // ------------------------------------------------------------------------
    if (!st_reg.sync.mrs_n || !st_reg.sync.prs_n) begin
      mem_wr.en = 1'b0;
      st_next.wr_ptr = '0;
      st_next.rd_ptr = '0;
      st_next.mem_cnt = '0;
      st_next.inflight = 1'b0;
      st_next.buf_cnt = 2'h0;
      st_next.buf_head = 1'b0;
      st_next.asm_idx = 2'h0;
      st_next.cur_rem = 2'h0;
      st_next.out_valid = 1'b0;
      st_next.fall_cnt = 2'h0;
    end
    if (!st_reg.sync.mrs_n) begin
      st_next.cfg = decode_cfg(st_reg.sync);
      st_next.q = '0;
    end

    // ------------------------------------------------------------------------
    // flags from the coming state so they leave flops
    // ------------------------------------------------------------------------
    stored_next = st_next.mem_cnt + CW'(st_next.inflight) + CW'(st_next.buf_cnt);
    if (st_next.cfg.fall_through) begin
      st_next.ef_n = !st_next.out_valid;
      st_next.ff_n = (stored_next == DEPTH_CNT);
    end else begin
      st_next.ef_n = (st_next.cur_rem != 2'h0) || (stored_next != '0);
      st_next.ff_n = (stored_next != DEPTH_CNT);
    end
    st_next.hf_n = (stored_next < HALF_CNT);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign output_data_bus = st_reg.q;
  assign output_data_oe = st_reg.q_oe;
  assign empty_flag_n = st_reg.ef_n;
  assign full_flag_n = st_reg.ff_n;
  assign half_level_flag_n = st_reg.hf_n;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  AST_DEPTH_BOUND: assert property (stored <= DEPTH_CNT)
    else $error("stored count above depth");
  AST_WIDTH_PAIR: assert property (st_reg.cfg.in_width == W36 || st_reg.cfg.out_width == W36)
    else $error("illegal width pairing");
  AST_CLOCKED_WRITE: assert property (!st_reg.cfg.wr_strobe && st_reg.sync.wclk && !st_reg.wclk_prev &&
      !st_reg.sync.wen_n && !full && st_reg.cfg.in_width == W36 && st_reg.sync.mrs_n && st_reg.sync.prs_n
      |=> st_reg.wr_ptr == $past(st_reg.wr_ptr) + 1'b1)
    else $error("clocked write not stored");
  AST_FULL_IGNORE: assert property (full && wr_evt && st_reg.sync.mrs_n && st_reg.sync.prs_n
      |=> $stable(st_reg.wr_ptr))
    else $error("write accepted while full");
  AST_STD_HOLD: assert property (!st_reg.cfg.fall_through && !rd_evt && st_reg.sync.mrs_n
      |=> $stable(st_reg.q))
    else $error("standard output changed without read");
  AST_FALL_THIRD: assert property (st_reg.cfg.fall_through && !st_reg.out_valid && avail && rclk_edge &&
      st_reg.fall_cnt == 2'h2 && st_reg.sync.mrs_n && st_reg.sync.prs_n |=> st_reg.out_valid ##1 !st_reg.ef_n)
    else $error("first word did not fall through on third edge");
  AST_FALL_EARLY: assert property (st_reg.cfg.fall_through && !st_reg.out_valid && st_reg.fall_cnt != 2'h2
      |=> !st_reg.out_valid)
    else $error("word fell through early");
  AST_HIZ: assert property (st_reg.sync.oe_n |=> !output_data_oe)
    else $error("outputs driven while disabled");
  AST_PARTIAL_KEEP: assert property (!st_reg.sync.prs_n && st_reg.sync.mrs_n
      |=> $stable(st_reg.cfg) && stored == '0)
    else $error("partial reset changed settings or kept data");
  AST_MASTER_CLEAR: assert property (!st_reg.sync.mrs_n |=> stored == '0 && !st_reg.out_valid ##1
      st_reg.hf_n)
    else $error("master reset left data");

  // a granted read must move a piece or a buffered word onto the outputs
  AST_CLOCKED_READ: assert property (!st_reg.cfg.fall_through && !st_reg.cfg.rd_strobe && rclk_edge &&
      !st_reg.sync.ren_n && avail && st_reg.sync.mrs_n && st_reg.sync.prs_n
      |=> st_reg.cur_rem != $past(st_reg.cur_rem) || st_reg.buf_cnt != 2'($past(st_reg.buf_cnt) + $past(push)))
    else $error("clocked read not performed");
  AST_STROBE_READ: assert property (!st_reg.cfg.fall_through && st_reg.cfg.rd_strobe && st_reg.sync.rstb &&
      !st_reg.rstb_prev && avail && st_reg.sync.mrs_n && st_reg.sync.prs_n
      |=> st_reg.cur_rem != $past(st_reg.cur_rem) || st_reg.buf_cnt != 2'($past(st_reg.buf_cnt) + $past(push)))
    else $error("strobe read not performed");
  AST_STROBE_WRITE: assert property (st_reg.cfg.wr_strobe && st_reg.sync.wstb && !st_reg.wstb_prev &&
      !full && st_reg.cfg.in_width == W36 && st_reg.sync.mrs_n && st_reg.sync.prs_n
      |=> st_reg.wr_ptr == $past(st_reg.wr_ptr) + 1'b1)
    else $error("strobe write not stored");
  AST_EMPTY_IGNORE: assert property (!st_reg.cfg.fall_through && rd_evt && !avail && st_reg.sync.mrs_n
      |=> $stable(st_reg.q) && $stable(st_reg.cur_rem))
    else $error("read accepted while empty");
  AST_OE_DRIVE: assert property (!st_reg.sync.oe_n && (st_reg.cfg.rd_strobe || !st_reg.sync.rcs_n)
      |=> output_data_oe)
    else $error("outputs released while enabled");
  // flags leave flops fed from the coming state, so they track the stored count without lag
  AST_HALF_FLAG: assert property (st_reg.hf_n == (stored < HALF_CNT))
    else $error("half flag disagrees with stored count");
  AST_FULL_FLAG: assert property (!st_reg.cfg.fall_through |-> st_reg.ff_n == (stored != DEPTH_CNT))
    else $error("full flag disagrees with stored count");

endmodule
`default_nettype wire

// *** bench/bmf_partner.sv ***
// producer and consumer model that drives the write and read port pins
`timescale 1ns/1ps
`default_nettype none
module bmf_partner (
  input wire logic clock,
  output logic wclk,
  output logic wstb,
  output logic wen_n,
  output logic [bmf_pkg::DW-1:0] d,
  output logic rclk,
  output logic rstb,
  output logic ren_n
);
  import bmf_pkg::*;

  // ====================
  // idle levels
  // ====================
  initial begin
    wclk = 1'b0;
    wstb = 1'b0;
    wen_n = 1'b1;
    d = '0;
    rclk = 1'b0;
    rstb = 1'b0;
    ren_n = 1'b1;
  end

  // ====================
  // producer
  // ====================
  // port clocks stand still between transfers; released data shows the inverse, never a stale copy
  task automatic put(input logic [DW-1:0] v, input bit strobe, input int gap);
    @(posedge clock);
    d <= v;
    wen_n <= 1'b0;
    if (strobe) begin
      wstb <= 1'b1;
    end else begin
      wclk <= 1'b1;
    end
    repeat (3) @(posedge clock);
    wclk <= 1'b0;
    wstb <= 1'b0;
    repeat (2 + gap) @(posedge clock);
    d <= ~v;
    if (!strobe) begin
      wen_n <= 1'b1;
    end
    #1;
  endtask

  // ====================
  // consumer
  // ====================
  // strobe reads keep the enable low for good; en high asks fall-through mode for a further word, en low gives a bare clock edge
  task automatic pull(input bit strobe, input bit en, input int gap);
    @(posedge clock);
    ren_n <= strobe ? 1'b0 : !en;
    if (strobe) begin
      rstb <= 1'b1;
    end else begin
      rclk <= 1'b1;
    end
    repeat (3) @(posedge clock);
    rclk <= 1'b0;
    rstb <= 1'b0;
    repeat (2 + gap) @(posedge clock);
    if (!strobe) begin
      ren_n <= 1'b1;
    end
    #1;
  endtask
endmodule
`default_nettype wire

// *** bench/bmf_top_bench.sv ***
// self-checking bench of the bus-matching buffer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module bmf_top_bench;
  import bmf_pkg::*;

  // ====================
  // signals
  // ====================
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic rcs_n = 1'b0, oe_n = 1'b0, mrs_n = 1'b1, prs_n = 1'b1;
  logic iw = 1'b0, ow = 1'b0, bm = 1'b0, ft = 1'b0, be_n = 1'b1, ws = 1'b0, rs = 1'b0;
  wire logic wclk, wstb, wen_n, rclk, rstb, ren_n;
  wire logic [DW-1:0] d;
  logic [DW-1:0] q;
  logic oe, ef_n, ff_n, hf_n;
  wire [DW-1:0] q_pins;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [DW-1:0] w, w2;
  logic [DW-1:0] fifo_q[$];
  logic [2:0] cfgs[5] = '{3'b000, 3'b100, 3'b101, 3'b110, 3'b111};
  int inc, outc;

  assign q_pins = oe ? q : 'z;

  initial begin
    forever #2 clock = ~clock;
  end

  bmf_partner u_bmf_partner (.clock(clock), .wclk(wclk), .wstb(wstb), .wen_n(wen_n), .d(d),
                             .rclk(rclk), .rstb(rstb), .ren_n(ren_n));

  bmf_top u_bmf_top (
    .clock(clock), .rstn(rstn), .write_clock_pin(wclk), .write_strobe_pin(wstb), .write_enable_n(wen_n),
    .input_data_bus(d), .read_clock_pin(rclk), .read_strobe_pin(rstb), .read_enable_n(ren_n),
    .output_chip_select_n(rcs_n), .output_enable_n(oe_n), .master_reset_n(mrs_n), .partial_reset_n(prs_n),
    .input_width_pin(iw), .output_width_pin(ow), .width_matching_select(bm),
    .fall_through_select_serial_in(ft), .byte_order_select_n(be_n), .write_strobe_select(ws),
    .read_strobe_select(rs), .output_data_bus(q), .output_data_oe(oe), .empty_flag_n(ef_n),
    .full_flag_n(ff_n), .half_level_flag_n(hf_n));

  // ====================
  // helpers
  // ====================
  // wc: 0 = 36 bits, 1 = 18 bits, 2 = 9 bits; piece lands in the low bits
  function automatic logic [DW-1:0] exp_piece(input logic [DW-1:0] v, input int wc, input int idx, input bit big);
    int n;
    int sz;
    int pos;
    logic [DW-1:0] m;
    n = 1 << wc;
    sz = 36 / n;
    pos = big ? n - 1 - idx : idx;
    m = (36'h1 << sz) - 36'h1;
    return (v >> (pos * sz)) & m;
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic mreset(input logic [2:0] c, input bit fall, input bit big, input bit wsel, input bit rsel);
    @(posedge clock);
    {bm, iw, ow} <= c;
    ft <= fall;
    be_n <= !big;
    ws <= wsel;
    rs <= rsel;
    mrs_n <= 1'b0;
    repeat (6) @(posedge clock);
    mrs_n <= 1'b1;
    idle(6);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end

  // ====================
  // tests
  // ====================
  initial begin
    void'($urandom(32'hf2e5));
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    idle(1);
    `CHK({ef_n, ff_n, hf_n}, 3'b011)
    // bus widths, byte order and port kinds, each pairing in turn
    for (int i = 0; i < 5; i++) begin
      mreset(cfgs[i], 1'b0, i[0], i[1], i[0]); // strobe reads kept in standard mode, chip select low
      inc = (cfgs[i][2] && cfgs[i][1]) ? (cfgs[i][0] ? 2 : 1) : 0;
      outc = (cfgs[i][2] && !cfgs[i][1]) ? (cfgs[i][0] ? 2 : 1) : 0;
      for (int k = 0; k < 2; k++) begin
        w = DW'({$urandom(), $urandom()});
        for (int p = 0; p < (1 << inc); p++) begin
          u_bmf_partner.put(exp_piece(w, inc, p, i[0]), i[1], $urandom_range(0, 3));
        end
        idle(4);
        if (k == 0) begin
          `CHK(q, 36'h0)
          `CHK(ef_n, 1'b1)
        end
        for (int p = 0; p < (1 << outc); p++) begin
          u_bmf_partner.pull(i[0], 1'b1, $urandom_range(0, 3));
          `CHK(q, exp_piece(w, outc, p, i[0]))
        end
      end
      idle(2);
      `CHK(ef_n, 1'b0)
    end
    // fill to full, one refused write, drain, one refused read
    mreset(3'b000, 1'b0, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 1024; k++) begin
      w = DW'({$urandom(), $urandom()});
      fifo_q.push_back(w);
      u_bmf_partner.put(w, 1'b0, 0);
      if (k == 511 || k == 512) begin
        idle(2);
        `CHK(hf_n, k == 511 ? 1'b1 : 1'b0)
      end
    end
    idle(2);
    `CHK(ff_n, 1'b0)
    u_bmf_partner.put(36'h0_dead_beef, 1'b0, 0);
    idle(4);
    for (int k = 0; k < 1024; k++) begin
      u_bmf_partner.pull(1'b0, 1'b1, 0);
      `CHK(q, fifo_q.pop_front())
      if (k == 0) begin
        `CHK(ff_n, 1'b1)
      end
    end
    idle(2);
    `CHK(ef_n, 1'b0)
    u_bmf_partner.pull(1'b0, 1'b1, 0);
    `CHK(q, w)
    // fall-through timing, later words by enable only
    mreset(3'b000, 1'b1, 1'b0, 1'b0, 1'b0);
    `CHK({ef_n, ff_n}, 2'b10)
    w = DW'({$urandom(), $urandom()});
    w2 = ~w;
    u_bmf_partner.put(w, 1'b0, 0);
    idle(4);
    for (int k = 0; k < 3; k++) begin
      u_bmf_partner.pull(1'b0, 1'b0, 0);
    end
    idle(2);
    `CHK(q, w)
    `CHK(ef_n, 1'b0)
    u_bmf_partner.put(w2, 1'b0, 1);
    idle(4);
    u_bmf_partner.pull(1'b0, 1'b0, 0);
    u_bmf_partner.pull(1'b0, 1'b0, 0);
    `CHK(q, w)
    u_bmf_partner.pull(1'b0, 1'b1, 0);
    `CHK(q, w2)
    // output drive follows output enable
    @(posedge clock);
    oe_n <= 1'b1;
    idle(4);
    `CHK(q_pins, {DW{1'bz}})
    @(posedge clock);
    oe_n <= 1'b0;
    idle(4);
    `CHK(oe, 1'b1)
    // chip select gates the drive while reads are clocked
    @(posedge clock);
    rcs_n <= 1'b1;
    idle(4);
    `CHK(oe, 1'b0)
    @(posedge clock);
    rcs_n <= 1'b0;
    idle(4);
    // partial reset drops data, fall-through stays selected
    u_bmf_partner.put(36'h1_2345_6789, 1'b0, 0);
    @(posedge clock);
    prs_n <= 1'b0;
    repeat (5) @(posedge clock);
    prs_n <= 1'b1;
    idle(8);
    `CHK({ef_n, ff_n}, 2'b10)
    u_bmf_partner.put(w, 1'b0, 0);
    idle(4);
    for (int k = 0; k < 3; k++) begin
      u_bmf_partner.pull(1'b0, 1'b0, 0);
    end
    idle(2);
    `CHK(q, w)
    end_sim();
  end
endmodule
`default_nettype wire
